// ==== hw/eew_pkg.sv ====
// Function
// - Data changes only while clock low.
// - Falling data with clock high starts commands.
// - Rising data with clock high stops, anywhere.
// - Acknowledge each eight-bit word on ninth clock.
// - Standby at power-up and after finished stop.
// - Device word starts with fixed 1010 pattern.
// - Bits three to one match chip selects.
// - Lowest device word bit selects read or write.
// - Match acknowledges; mismatch stays silent, returns standby.
// - Write-protect high blocks all array writes.
// - Byte write: two address bytes, one data.
// - Stop starts timed program cycle, inputs locked.
// - Page write accepts up to 63 more bytes.
// - Only low six address bits increment, wrapping.
// - Polling acknowledged only after programming ends.
// - Sample on rising clock, drive after falling.
// - 512 pages of 64; first address MSB ignored.
package eew_pkg;

  // Array geometry: the page offset is the low part of the word address.
  localparam int ADDR_W      = 15;
  localparam int OFFS_W      = 6;
  localparam int ROW_W       = ADDR_W - OFFS_W;
  localparam int ARRAY_BYTES = 32768;
  localparam int PAGE_BYTES  = 64;

  // Device address word and bit framing.
  localparam logic [3:0]        DEV_CODE = 4'ha;
  localparam logic [3:0]        LAST_BIT = 4'h7;
  localparam logic [3:0]        ACK_BIT  = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;

  // Program cycle time and its count of system clocks, rounded down as a longest time.
  localparam int CLK_PERIOD_NS            = 20;
  localparam int PROGRAM_CYCLE_TIME_MS    = 5;
  localparam int PROG_CYCLES              = (PROGRAM_CYCLE_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int TIMER_W                  = 18;

  // Byte phase of the link engine.
  typedef enum logic [2:0] {PH_IDLE, PH_DEV, PH_AHI, PH_ALO, PH_DATA} eew_phase_t;

  // Core control state.
  typedef enum logic [1:0] {CT_IDLE, CT_RECV, CT_PROG} eew_ctl_t;

  // Next address within the same page; the row never moves.
  function automatic logic [ADDR_W-1:0] page_next(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:OFFS_W], a[OFFS_W-1:0] + 6'h01};
  endfunction

endpackage

// ==== hw/eew_bus_if.sv ====
// Carries byte events from the link engine and array traffic from the core.
interface eew_bus_if;
  logic                         ev_tog;
  logic                         ev_is_data;
  logic [eew_pkg::ADDR_W-1:0]   ev_addr;
  logic [7:0]                   ev_data;
  logic                         busy;
  logic                         mem_we;
  logic [eew_pkg::ADDR_W-1:0]   mem_waddr;
  logic [7:0]                   mem_wdata;
  logic [eew_pkg::ADDR_W-1:0]   mem_raddr;
  logic [7:0]                   mem_rdata;

  modport eng (output ev_tog, ev_is_data, ev_addr, ev_data, input busy);
  modport mem (input mem_we, mem_waddr, mem_wdata, mem_raddr, output mem_rdata);
endinterface

// ==== hw/eew_mem.sv ====
module eew_mem (
  // System clock.
  input  wire logic i_mclk,
  // Array port.
  eew_bus_if.mem    bus
);

  logic [7:0] array_q [eew_pkg::ARRAY_BYTES];
  logic [7:0] rdata_q;

  // The array holds no reset; the read word is registered for timing.
  always_ff @(posedge i_mclk) begin
    if (bus.mem_we) begin
      array_q[bus.mem_waddr] <= bus.mem_wdata;
    end
    rdata_q <= array_q[bus.mem_raddr];
  end

  assign bus.mem_rdata = rdata_q;

endmodule // eew_mem

// ==== hw/eew_link.sv ====
module eew_link (
  // Link clock and reset.
  input  wire logic       i_scl,
  input  wire logic       i_resetn,
  // Serial data pin and chip-select straps.
  input  wire logic       i_sda,
  input  wire logic [2:0] i_chip_sel,
  // Data pin pull-down enable.
  output logic            o_sda_oe,
  // Byte events towards the core.
  eew_bus_if.eng          bus
);

  typedef struct packed {
    eew_pkg::eew_phase_t        phase;
    logic [3:0]                 cnt;
    logic [6:0]                 shift;
    logic [eew_pkg::ADDR_W-1:0] addr;
    logic                       ack;
    logic                       start_ack;
    logic                       stop_ack;
    logic                       busy_m;
    logic                       busy_s;
    logic [2:0]                 cs_m;
    logic [2:0]                 cs_s;
    logic                       ev_tog;
    logic                       ev_is_data;
    logic [eew_pkg::ADDR_W-1:0] ev_addr;
    logic [7:0]                 ev_data;
  } eew_link_t;

  eew_link_t  st_q;
  eew_link_t  st_d;
  logic       start_tog_q;
  logic       stop_tog_q;
  logic       stop_w;
  logic       oe_q;
  logic       start_w;
  logic [7:0] byte_w;
  logic       hit_w;

  // The clock gives no edge during a start, so the falling data edge itself records it.
  always_ff @(negedge i_sda or negedge i_resetn) begin
    if (!i_resetn) begin
      start_tog_q <= 1'b0;
    end else if (i_scl) begin
      start_tog_q <= ~start_tog_q;
    end
  end

  // A stop gives no clock edge either; without this record, idle clocks would frame a byte.
  always_ff @(posedge i_sda or negedge i_resetn) begin
    if (!i_resetn) begin
      stop_tog_q <= 1'b0;
    end else if (i_scl) begin
      stop_tog_q <= ~stop_tog_q;
    end
  end

  // Current byte and device word compare; a busy core refuses the poll.
  assign start_w = start_tog_q ^ st_q.start_ack;
  assign stop_w  = stop_tog_q ^ st_q.stop_ack;
  assign byte_w  = {st_q.shift, i_sda};
  assign hit_w   = (byte_w[7:4] == eew_pkg::DEV_CODE)
                && (byte_w[3:1] == st_q.cs_s)
                && !st_q.busy_s;

  // Bit and byte sequencing on rising clock edges.
  always_comb begin
    st_d           = st_q;
    st_d.busy_m    = bus.busy;
    st_d.busy_s    = st_q.busy_m;
    st_d.cs_m      = i_chip_sel;
    st_d.cs_s      = st_q.cs_m;
    st_d.start_ack = start_tog_q;
    st_d.stop_ack  = stop_tog_q;
    st_d.ack       = 1'b0;
    if (start_w) begin
      st_d.phase = eew_pkg::PH_DEV;
      st_d.cnt   = 4'h1;
      st_d.shift = {6'h00, i_sda};
    end else if (stop_w) begin
      st_d.phase = eew_pkg::PH_IDLE;
      st_d.cnt   = 4'h0;
    end else if (st_q.cnt == eew_pkg::ACK_BIT) begin
      st_d.cnt = 4'h0;
    end else if (st_q.phase != eew_pkg::PH_IDLE) begin
      st_d.cnt   = st_q.cnt + 4'h1;
      st_d.shift = byte_w[6:0];
      if (st_q.cnt == eew_pkg::LAST_BIT) begin
        st_d.ack = 1'b1;
        case (st_q.phase)
          eew_pkg::PH_DEV: begin
            st_d.ack   = hit_w;
            st_d.phase = (hit_w && !byte_w[0]) ? eew_pkg::PH_AHI : eew_pkg::PH_IDLE;
          end
          eew_pkg::PH_AHI: begin
            st_d.addr[eew_pkg::ADDR_W-1:8] = byte_w[6:0];
            st_d.phase                     = eew_pkg::PH_ALO;
          end
          eew_pkg::PH_ALO: begin
            st_d.addr[7:0]  = byte_w;
            st_d.phase      = eew_pkg::PH_DATA;
            st_d.ev_tog     = ~st_q.ev_tog;
            st_d.ev_is_data = 1'b0;
            st_d.ev_addr    = {st_q.addr[eew_pkg::ADDR_W-1:8], byte_w};
          end
          eew_pkg::PH_DATA: begin
            st_d.ev_tog     = ~st_q.ev_tog;
            st_d.ev_is_data = 1'b1;
            st_d.ev_addr    = st_q.addr;
            st_d.ev_data    = byte_w;
            st_d.addr       = eew_pkg::page_next(st_q.addr);
          end
          default: begin
            st_d.ack   = 1'b0;
            st_d.phase = eew_pkg::PH_IDLE;
          end
        endcase
      end
    end
  end

  // Link state register.
  always_ff @(posedge i_scl or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // The acknowledge moves only after a falling edge, so it is steady while the clock is high.
  always_ff @(negedge i_scl or negedge i_resetn) begin
    if (!i_resetn) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= st_q.ack;
    end
  end

  // Outputs towards the pin and the core.
  assign o_sda_oe       = oe_q;
  assign bus.ev_tog     = st_q.ev_tog;
  assign bus.ev_is_data = st_q.ev_is_data;
  assign bus.ev_addr    = st_q.ev_addr;
  assign bus.ev_data    = st_q.ev_data;

  // Acknowledge only on the ninth clock, for one clock.
  ack_ninth_a: assert property (@(posedge i_scl) disable iff (!i_resetn)
    st_q.ack |-> st_q.cnt == eew_pkg::ACK_BIT ##1 !st_q.ack)
    else $error("Acknowledge outside the ninth clock.");

  // A foreign chip select is never acknowledged.
  dev_miss_a: assert property (@(posedge i_scl) disable iff (!i_resetn)
    st_q.phase == eew_pkg::PH_DEV && st_q.cnt == eew_pkg::LAST_BIT && !start_w
    && byte_w[3:1] != st_q.cs_s |=> !st_q.ack && st_q.phase == eew_pkg::PH_IDLE)
    else $error("Device word with another chip select was acknowledged.");

  // No acknowledge while the program cycle runs.
  poll_busy_a: assert property (@(posedge i_scl) disable iff (!i_resetn)
    st_q.phase == eew_pkg::PH_DEV && st_q.cnt == eew_pkg::LAST_BIT && !start_w
    && st_q.busy_s |=> !st_q.ack)
    else $error("Poll acknowledged during programming.");

  // Data bytes advance only the page offset.
  page_wrap_a: assert property (@(posedge i_scl) disable iff (!i_resetn)
    $changed(st_q.ev_tog) && st_q.ev_is_data |-> st_q.addr
    == {st_q.ev_addr[eew_pkg::ADDR_W-1:6], st_q.ev_addr[5:0] + 6'h01})
    else $error("Word address left its page.");

  // A start always restarts the device word.
  start_frame_a: assert property (@(posedge i_scl) disable iff (!i_resetn)
    start_w |=> st_q.phase == eew_pkg::PH_DEV && st_q.cnt == 4'h1)
    else $error("Start did not restart framing.");

  // A stop ends the frame at the next clock edge.
  stop_frame_a: assert property (@(posedge i_scl) disable iff (!i_resetn)
    stop_w && !start_w |=> st_q.phase == eew_pkg::PH_IDLE && !st_q.ack)
    else $error("Stop did not end framing.");

endmodule // eew_link

// ==== hw/eew_top.sv ====
module eew_top #(
  parameter int PROG_CYCLES = eew_pkg::PROG_CYCLES
) (
  // System clock and reset.
  input  wire logic                     i_mclk,
  input  wire logic                     i_resetn,
  // Two-wire bus; the clock pin is the link clock.
  input  wire logic                     i_scl,
  input  wire logic                     i_sda,
  output logic                          o_sda_o,
  output logic                          o_sda_oe,
  // Hardwired straps.
  input  wire logic                     i_chip_select_bit_2,
  input  wire logic                     i_chip_select_bit_1,
  input  wire logic                     i_chip_select_bit_0,
  input  wire logic                     i_write_prot,
  // Status and link to the read path.
  output logic                          o_standby,
  output logic                          o_busy,
  output logic [eew_pkg::ADDR_W-1:0]    o_word_addr,
  output logic [7:0]                    o_rd_data
);

  localparam logic [eew_pkg::TIMER_W-1:0] PROG_LOAD = eew_pkg::TIMER_W'(PROG_CYCLES - 1);

  typedef struct packed {
    logic [2:0]                                    scl_sync;
    logic [2:0]                                    sda_sync;
    logic [1:0]                                    wp_sync;
    logic [2:0]                                    ev_sync;
    eew_pkg::eew_ctl_t                             ctl;
    logic [eew_pkg::PAGE_BYTES-1:0]                valid;
    logic [eew_pkg::PAGE_BYTES-1:0][7:0]           page;
    logic [eew_pkg::ROW_W-1:0]                     row;
    logic [eew_pkg::ADDR_W-1:0]                    word_addr;
    logic [eew_pkg::OFFS_W-1:0]                    idx;
    logic [eew_pkg::TIMER_W-1:0]                   timer;
    logic                                          we;
    logic [eew_pkg::ADDR_W-1:0]                    waddr;
    logic [7:0]                                    wdata;
    logic                                          standby;
  } eew_core_t;

  eew_core_t cr_q;
  eew_core_t cr_d;
  logic      start_w;
  logic      stop_w;
  logic      event_w;
  logic      prog_w;

  eew_bus_if u_bus ();

  // Link engine on the bus clock.
  eew_link u_link (
    .i_scl      (i_scl),
    .i_resetn   (i_resetn),
    .i_sda      (i_sda),
    .i_chip_sel ({i_chip_select_bit_2, i_chip_select_bit_1, i_chip_select_bit_0}),
    .o_sda_oe   (o_sda_oe),
    .bus        (u_bus.eng)
  );

  // Nonvolatile array.
  eew_mem u_mem (
    .i_mclk (i_mclk),
    .bus    (u_bus.mem)
  );

  // Bus conditions seen through the synchronisers; only the second and third stages are read.
  assign start_w = cr_q.scl_sync[1] && cr_q.scl_sync[2]
                && cr_q.sda_sync[2] && !cr_q.sda_sync[1];
  assign stop_w  = cr_q.scl_sync[1] && cr_q.scl_sync[2]
                && !cr_q.sda_sync[2] && cr_q.sda_sync[1];
  assign event_w = cr_q.ev_sync[1] ^ cr_q.ev_sync[2];
  assign prog_w  = (cr_q.ctl == eew_pkg::CT_PROG);

  // Core sequencing. A stop is caught here because the bus clock stands still after it.
  // Bytes are gathered in a page latch and only committed after the stop, so a repeated
  // start (the dummy write of a random read) leaves the array untouched.
  always_comb begin
    cr_d          = cr_q;
    cr_d.scl_sync = {cr_q.scl_sync[1:0], i_scl};
    cr_d.sda_sync = {cr_q.sda_sync[1:0], i_sda};
    cr_d.wp_sync  = {cr_q.wp_sync[0], i_write_prot};
    cr_d.ev_sync  = {cr_q.ev_sync[1:0], u_bus.ev_tog};
    cr_d.we       = 1'b0;
    case (cr_q.ctl)
      eew_pkg::CT_IDLE, eew_pkg::CT_RECV: begin
        if (start_w) begin
          cr_d.ctl     = eew_pkg::CT_RECV;
          cr_d.standby = 1'b0;
          cr_d.valid   = '0;
        end else if (stop_w) begin
          if ((|cr_q.valid) && !cr_q.wp_sync[1]) begin
            cr_d.ctl   = eew_pkg::CT_PROG;
            cr_d.idx   = '0;
            cr_d.timer = PROG_LOAD;
          end else begin
            cr_d.ctl     = eew_pkg::CT_IDLE;
            cr_d.standby = 1'b1;
            cr_d.valid   = '0;
          end
        end
        // A byte event comes last so that its set wins over a clear in the same clock.
        // The payload is stable: it was launched two clocks before its toggle arrived.
        if (event_w) begin
          cr_d.standby = 1'b0;
          if (u_bus.ev_is_data) begin
            cr_d.valid[u_bus.ev_addr[eew_pkg::OFFS_W-1:0]] = 1'b1;
            cr_d.page[u_bus.ev_addr[eew_pkg::OFFS_W-1:0]]  = u_bus.ev_data;
            cr_d.row       = u_bus.ev_addr[eew_pkg::ADDR_W-1:eew_pkg::OFFS_W];
            cr_d.word_addr = eew_pkg::page_next(u_bus.ev_addr);
          end else begin
            cr_d.word_addr = u_bus.ev_addr;
          end
        end
      end
      eew_pkg::CT_PROG: begin
        // Bus conditions and byte events are ignored for the whole cycle.
        cr_d.we              = cr_q.valid[cr_q.idx];
        cr_d.waddr           = {cr_q.row, cr_q.idx};
        cr_d.wdata           = cr_q.page[cr_q.idx];
        cr_d.valid[cr_q.idx] = 1'b0;
        cr_d.idx             = cr_q.idx + 6'h01;
        cr_d.timer           = cr_q.timer - 18'h0_0001;
        if (cr_q.timer == '0) begin
          cr_d.ctl     = eew_pkg::CT_IDLE;
          cr_d.standby = 1'b1;
        end
      end
      default: begin
        cr_d.ctl = eew_pkg::CT_IDLE;
      end
    endcase
  end

  // Core state register; the idle bus is high, so the clock and data synchronisers start high.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cr_q           <= '0;
      cr_q.scl_sync  <= 3'h7;
      cr_q.sda_sync  <= 3'h7;
      cr_q.word_addr <= eew_pkg::ADDR_RST;
      cr_q.standby   <= 1'b1;
    end else begin
      cr_q <= cr_d;
    end
  end

  // Array and engine connections.
  assign u_bus.busy      = prog_w;
  assign u_bus.mem_we    = cr_q.we;
  assign u_bus.mem_waddr = cr_q.waddr;
  assign u_bus.mem_wdata = cr_q.wdata;
  assign u_bus.mem_raddr = cr_q.word_addr;

  // Pin and status outputs. The data pin is open drain: it is only ever pulled low.
  assign o_sda_o     = 1'b0;
  assign o_standby   = cr_q.standby;
  assign o_busy      = prog_w;
  assign o_word_addr = cr_q.word_addr;
  assign o_rd_data   = u_bus.mem_rdata;

  // A stop that closes a write with gathered bytes.
  sequence s_write_stop;
    stop_w && !prog_w && (|cr_q.valid) && !cr_q.wp_sync[1];
  endsequence

  // The program cycle freshly loaded.
  sequence s_prog_loaded;
    prog_w && cr_q.timer == PROG_LOAD && !cr_q.standby;
  endsequence

  // Stop starts the program cycle and it runs on for several clocks.
  prog_start_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    s_write_stop |=> s_prog_loaded ##1 prog_w [*4])
    else $error("Program cycle did not start after a write stop.");

  // Protected array: a stop discards the gathered bytes.
  wp_block_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    stop_w && !prog_w && cr_q.wp_sync[1] |=> !prog_w && cr_q.valid == '0 && cr_q.standby)
    else $error("Write went ahead while protected.");

  // The cycle holds until its counter expires.
  prog_hold_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    prog_w && cr_q.timer != '0 |=> prog_w && $stable(cr_q.row))
    else $error("Program cycle ended early.");

  // Standby follows the end of the cycle.
  prog_end_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    prog_w && cr_q.timer == '0 |=> cr_q.ctl == eew_pkg::CT_IDLE && cr_q.standby
    && cr_q.valid == '0)
    else $error("No standby after programming.");

  // A start discards bytes of an unfinished write.
  start_clear_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    start_w && !prog_w && !event_w |=> cr_q.valid == '0 && !cr_q.standby)
    else $error("Start did not discard pending bytes.");

  // The array is written only inside the program cycle.
  write_gate_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    u_bus.mem_we |-> $past(prog_w) && prog_w)
    else $error("Array written outside the program cycle.");

  // A stop with nothing to write goes straight to standby.
  stop_idle_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    stop_w && !prog_w && cr_q.valid == '0 |=> cr_q.standby && !prog_w)
    else $error("Stop without data did not reach standby.");

  // Inputs are locked during programming.
  prog_lock_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    prog_w && (start_w || event_w) && cr_q.timer != '0 |=> prog_w)
    else $error("Bus activity broke the program cycle.");

endmodule // eew_top

// ==== tb/eew_ctl_model.sv ====
module eew_ctl_model (
  // Bus lines driven by the controller; data is open drain.
  output logic      o_scl,
  output logic      o_sda_low,
  // Resolved data line.
  input  wire logic i_sda
);
  timeunit 1ns;
  timeprecision 10ps;

  // A quarter of the 125 ns bus clock.
  localparam real Q = 31.25;

  // Bus idles with the clock parked high and data released.
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  // Data falls while the clock is high; works as a repeated start too.
  task automatic bus_start();
    o_sda_low = 1'b0;
    #(2*Q) o_scl = 1'b1;
    #(2*Q) o_sda_low = 1'b1;
    #(2*Q) o_scl = 1'b0;
    #(Q);
  endtask

  // Data only moves a quarter period after the clock falls.
  task automatic send_bit(input logic b);
    o_sda_low = ~b;
    #(Q) o_scl = 1'b1;
    #(2*Q) o_scl = 1'b0;
    #(Q);
  endtask

  // Ninth clock: release data and sample it mid-high.
  task automatic get_ack(output logic ack);
    o_sda_low = 1'b0;
    #(Q) o_scl = 1'b1;
    #(Q) ack = (i_sda === 1'b0);
    #(Q) o_scl = 1'b0;
    #(Q);
  endtask

  // Whole byte, most significant bit first, then the acknowledge clock.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    int i;
    for (i = 7; i >= 0; i--) send_bit(b[i]);
    get_ack(ack);
  endtask

  // Long clock-high time around the rising data edge lets slow samplers see it.
  task automatic bus_stop();
    o_sda_low = 1'b1;
    #(Q) o_scl = 1'b1;
    #(4*Q) o_sda_low = 1'b0;
    #(8*Q);
  endtask

  // Clock until data reads high, then start afresh.
  task automatic recover();
    int n;
    o_sda_low = 1'b0;
    for (n = 0; n < 9; n++) begin
      o_scl = 1'b0;
      #(2*Q) o_scl = 1'b1;
      #(2*Q);
      if (i_sda === 1'b1) break;
    end
    bus_start();
  endtask
endmodule // eew_ctl_model

// ==== tb/eew_top_tb_top.sv ====
module eew_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int         PROG  = 200;
  localparam logic [2:0] CS    = 3'h5;
  localparam logic [7:0] DEV_W = {eew_pkg::DEV_CODE, CS, 1'b0};

  logic                       i_mclk, i_resetn, i_write_prot;
  logic [2:0]                 cs_q;
  logic                       scl, ctl_low, sda;
  logic                       o_sda_o, o_sda_oe, o_standby, o_busy;
  logic [eew_pkg::ADDR_W-1:0] o_word_addr;
  logic [7:0]                 o_rd_data;
  int                         n_mismatch, checks;

  // The pull-up gives the high level; either party may pull low.
  assign sda = (o_sda_oe | ctl_low) ? 1'b0 : 1'b1;

  eew_top #(.PROG_CYCLES(PROG)) dut (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_scl(scl), .i_sda(sda),
    .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
    .i_chip_select_bit_2(cs_q[2]), .i_chip_select_bit_1(cs_q[1]),
    .i_chip_select_bit_0(cs_q[0]), .i_write_prot(i_write_prot),
    .o_standby(o_standby), .o_busy(o_busy), .o_word_addr(o_word_addr), .o_rd_data(o_rd_data));

  eew_ctl_model ctl (.o_scl(scl), .o_sda_low(ctl_low), .i_sda(sda));

  // System clock at 50 MHz.
  always #10 i_mclk = ~i_mclk;

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("Counts: %0d mismatches in %0d checks", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // The pin only ever pulls down, and never moves while the bus clock is high.
  always @(posedge i_mclk) if (i_resetn) check("drive value", 16'h0000, 16'(o_sda_o));
  always @(o_sda_oe) if (i_resetn && scl === 1'b1) check("oe on high", 16'h0000, 16'h0001);

  // Bounded wait on the program-cycle flag; a hang ends the run.
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    for (n = 0; n < lim && o_busy !== lvl; n++) @(posedge i_mclk);
    if (o_busy !== lvl) begin
      check("busy wait", 16'(lvl), 16'(o_busy));
      close_out();
    end
  endtask

  // Device word, both address bytes and n bytes counting up from seed.
  task automatic write_seq(input logic [7:0] dev, input logic [14:0] a, input int n,
                           input logic [7:0] seed, input logic half, output logic ok);
    logic ack;
    int   i;
    ctl.bus_start();
    ctl.send_byte(dev, ack);
    ok = ack;
    ctl.send_byte({1'b1, a[14:8]}, ack);
    ok &= ack;
    ctl.send_byte(a[7:0], ack);
    ok &= ack;
    for (i = 0; i < n; i++) begin
      ctl.send_byte(seed + 8'(i), ack);
      ok &= ack;
    end
    for (i = 0; i < 4 && half; i++) ctl.send_bit(1'b1);
    ctl.bus_stop();
  endtask

  // Dummy write loads the address; the read path then shows the stored byte.
  task automatic read_at(input logic [14:0] a, input logic [7:0] exp);
    logic ok;
    write_seq(DEV_W, a, 0, 8'h00, 1'b0, ok);
    repeat (4) @(posedge i_mclk);
    check("poll ack", 16'h0001, 16'(ok));
    check("word addr", 16'(a), 16'(o_word_addr));
    check("array byte", 16'(exp), 16'(o_rd_data));
  endtask

  task automatic s_reset();
    check("standby", 16'h0001, 16'(o_standby));
    check("busy", 16'h0000, 16'(o_busy));
    check("addr", 16'h0000, 16'(o_word_addr));
  endtask

  task automatic s_addressing();
    logic       ack;
    logic [7:0] dev;
    int         i;
    for (i = 0; i < 10; i++) begin
      dev = (i < 8) ? {eew_pkg::DEV_CODE, 3'(i), 1'b0} :
            (i == 8) ? {4'hb, CS, 1'b0} : {eew_pkg::DEV_CODE, CS, 1'b1};
      ctl.bus_start();
      ctl.send_byte(dev, ack);
      ctl.bus_stop();
      check("dev ack", 16'((i < 8 && 3'(i) == CS) || i == 9), 16'(ack));
      check("standby", 16'h0001, 16'(o_standby));
    end
  endtask

  // Byte write with polling refused while programming runs.
  task automatic s_byte_write();
    logic ok;
    write_seq(DEV_W, 15'h1234, 1, 8'ha5, 1'b0, ok);
    check("write acks", 16'h0001, 16'(ok));
    wait_busy(1'b1, 20);
    check("standby busy", 16'h0000, 16'(o_standby));
    ctl.bus_start();
    ctl.send_byte(DEV_W, ok);
    ctl.bus_stop();
    check("busy poll", 16'h0000, 16'(ok));
    wait_busy(1'b0, PROG + 100);
    check("standby done", 16'h0001, 16'(o_standby));
    read_at(15'h1234, 8'ha5);
  endtask

  // 66 bytes from offset 62: the offset wraps and the first two are overwritten.
  task automatic s_page_wrap();
    logic ok;
    write_seq(DEV_W, 15'h2abe, 66, 8'h10, 1'b0, ok);
    check("page acks", 16'h0001, 16'(ok));
    wait_busy(1'b1, 20);
    check("wrap addr", 16'h2a80, 16'(o_word_addr));
    wait_busy(1'b0, PROG + 100);
    read_at(15'h2abe, 8'h50);
    read_at(15'h2a80, 8'h12);
    read_at(15'h2abd, 8'h4f);
  endtask

  // Protected write leaves the array alone and never programs.
  task automatic s_protect();
    logic ok;
    @(posedge i_mclk) i_write_prot <= 1'b1;
    write_seq(DEV_W, 15'h2abe, 1, 8'h77, 1'b0, ok);
    repeat (20) @(posedge i_mclk);
    check("wp busy", 16'h0000, 16'(o_busy));
    check("wp standby", 16'h0001, 16'(o_standby));
    i_write_prot <= 1'b0;
    read_at(15'h2abe, 8'h50);
  endtask

  // Stop in mid-word still ends the write and starts programming.
  task automatic s_abort();
    logic ok;
    write_seq(DEV_W, 15'h0040, 1, 8'h3c, 1'b1, ok);
    wait_busy(1'b1, 20);
    wait_busy(1'b0, PROG + 100);
    // Clocks after a stop and without a start must not frame a byte.
    repeat (9) ctl.send_bit(1'b1);
    repeat (4) @(posedge i_mclk);
    check("idle clocks", 16'h0001, 16'(o_standby));
    ctl.recover();
    ctl.send_byte(DEV_W, ok);
    ctl.bus_stop();
    check("recover ack", 16'h0001, 16'(ok));
    read_at(15'h0040, 8'h3c);
  endtask

  initial begin
    i_mclk       = 1'b0;
    i_resetn     = 1'b0;
    i_write_prot = 1'b0;
    cs_q         = CS;
    n_mismatch   = 0;
    checks       = 0;
    repeat (4) @(posedge i_mclk);
    i_resetn <= 1'b1;
    repeat (5) @(posedge i_mclk);
    s_reset();
    s_addressing();
    s_byte_write();
    s_page_wrap();
    s_protect();
    s_abort();
    close_out();
  end
endmodule // eew_top_tb_top
